// *** core/prio_regs_pkg.sv ***
// Overview of operation
// - Each priority field is three bits; code 111 means level 7, the highest.
// - Code 001 means level 1, lowest enabled; codes between map linearly.
// - Code 000 disables the source so it can never be granted.
// - Bit positions holding no field read as zero, incl. each nibble's top bit.
// - At reset each field's top bit is one and its two low bits zero.
// - After any reset every source sits at priority level 4.
// - Reg 8: can1 event 14-12, can1 rx ready 10-8, spi2 event 6-4, error 2-0.
// - Reg 9: capture5 14-12, capture4 10-8, capture3 6-4, dma ch3 done 2-0.
// - Reg 10: compare7 14-12, compare6 10-8, compare5 6-4, capture6 2-0.
// - Reg 12: timer8 14-12, i2c2 master 10-8, i2c2 slave 6-4, timer7 2-0.
// - Reg 14: codec error 14-12, can2 event 2-0; bits 11-3 unused.
package prio_regs_pkg;
    localparam int NUM_REGS = 7;
    localparam int REG_W = 16;
    localparam int FIELD_W = 3;
    localparam int FIELDS_PER_REG = 4;
    localparam int NIBBLE_W = 4;
    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 12;
    localparam int APB_STRB_W = APB_DATA_W / 8;
    localparam int FLD0_LSB = 0;
    localparam int FLD1_LSB = 4;
    localparam int FLD2_LSB = 8;
    localparam int FLD3_LSB = 12;
    localparam int BYTE_LO_LSB = 0;
    localparam int BYTE_HI_LSB = 8;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_8_OFFS = 12'h000;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_9_OFFS = 12'h004;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_10_OFFS = 12'h008;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_11_OFFS = 12'h00c;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_12_OFFS = 12'h010;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_13_OFFS = 12'h014;
    localparam logic [APB_ADDR_W-1:0] PRIO_CTRL_14_OFFS = 12'h018;
    localparam logic [REG_W-1:0] MASK_FULL = 16'h7777;
    localparam logic [REG_W-1:0] MASK_REG11 = 16'h7707;
    localparam logic [REG_W-1:0] MASK_REG14 = 16'h7007;
    localparam logic [REG_W-1:0] RESET_PATTERN = 16'h4444;
    localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_MASKS = {
        MASK_REG14, MASK_FULL, MASK_FULL, MASK_REG11, MASK_FULL, MASK_FULL, MASK_FULL};
    localparam logic [FIELD_W-1:0] PRIO_DISABLED = 3'h0;
    localparam logic [FIELD_W-1:0] PRIO_LOWEST = 3'h1;
    localparam logic [FIELD_W-1:0] PRIO_DEFAULT = 3'h4;
    localparam logic [FIELD_W-1:0] PRIO_HIGHEST = 3'h7;
    localparam logic [2:0] IDX_REG8 = 3'h0;
    localparam logic [2:0] IDX_REG9 = 3'h1;
    localparam logic [2:0] IDX_REG10 = 3'h2;
    localparam logic [2:0] IDX_REG11 = 3'h3;
    localparam logic [2:0] IDX_REG12 = 3'h4;
    localparam logic [2:0] IDX_REG13 = 3'h5;
    localparam logic [2:0] IDX_REG14 = 3'h6;

    typedef logic [FIELD_W-1:0] prio_t;

    typedef struct packed {
        prio_t can1_event_prio;
        prio_t can1_rx_ready_prio;
        prio_t spi_two_event_prio;
        prio_t spi_two_error_prio;
        prio_t capture5_prio;
        prio_t capture4_prio;
        prio_t capture3_prio;
        prio_t dma_ch3_done_prio;
        prio_t compare7_prio;
        prio_t compare6_prio;
        prio_t compare5_prio;
        prio_t capture6_prio;
        prio_t timer6_prio;
        prio_t dma_ch4_done_prio;
        prio_t compare8_prio;
        prio_t timer8_prio;
        prio_t i2c_two_master_prio;
        prio_t i2c_two_slave_prio;
        prio_t timer7_prio;
        prio_t can2_rx_ready_prio;
        prio_t ext_irq4_prio;
        prio_t ext_irq3_prio;
        prio_t timer9_prio;
        prio_t codec_if_error_prio;
        prio_t can2_event_prio;
    } prio_fields_t;
endpackage : prio_regs_pkg

// *** core/prio_reg_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
module prio_reg_cell
    import prio_regs_pkg::*;
#(
    parameter logic [REG_W-1:0] IMPL_MASK = MASK_FULL
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [REG_W-1:0] wr_data_i,
    // Stored state
    output logic [REG_W-1:0] value_o,
    output logic [FIELDS_PER_REG-1:0] src_on_o
);
    logic [REG_W-1:0] value_reg;
    logic [FIELDS_PER_REG-1:0] src_on_reg;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_reg <= IMPL_MASK & RESET_PATTERN;
        end else if (wr_en_i) begin
            value_reg <= wr_data_i & IMPL_MASK;
        end
    end

    // Enable flags track the same write so they never lag the field
    for (genvar f = 0; f < FIELDS_PER_REG; f++) begin : g_fld
        localparam int LSB = f * NIBBLE_W;
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                src_on_reg[f] <= |(IMPL_MASK[LSB +: FIELD_W] & RESET_PATTERN[LSB +: FIELD_W]);
            end else if (wr_en_i) begin
                src_on_reg[f] <= |(wr_data_i[LSB +: FIELD_W] & IMPL_MASK[LSB +: FIELD_W]);
            end
        end
    end

    assign value_o = value_reg;
    assign src_on_o = src_on_reg;
endmodule : prio_reg_cell
`default_nettype wire

// *** core/prio_ctrl_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module prio_ctrl_regs
    import prio_regs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [APB_STRB_W-1:0] pstrb,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Arbitration side
    output prio_fields_t prio_o,
    output logic [NUM_REGS*FIELDS_PER_REG-1:0] src_on_o
);
    logic [NUM_REGS-1:0][REG_W-1:0] regs;
    logic [NUM_REGS-1:0][FIELDS_PER_REG-1:0] src_on;
    logic [NUM_REGS-1:0] wr_en;
    logic [APB_DATA_W-1:0] prdata_reg;
    logic [APB_DATA_W-1:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    logic [2:0] sel_idx;
    logic addr_hit;
    logic setup_ph;
    logic wr_fire;
    logic [REG_W-1:0] wr_word;

    assign setup_ph = psel && !penable;

    // Exact match only: misaligned or foreign addresses fall out as unmapped
    always_comb begin
        sel_idx = IDX_REG8;
        addr_hit = 1'b1;
        if (paddr == PRIO_CTRL_8_OFFS) begin
            sel_idx = IDX_REG8;
        end else if (paddr == PRIO_CTRL_9_OFFS) begin
            sel_idx = IDX_REG9;
        end else if (paddr == PRIO_CTRL_10_OFFS) begin
            sel_idx = IDX_REG10;
        end else if (paddr == PRIO_CTRL_11_OFFS) begin
            sel_idx = IDX_REG11;
        end else if (paddr == PRIO_CTRL_12_OFFS) begin
            sel_idx = IDX_REG12;
        end else if (paddr == PRIO_CTRL_13_OFFS) begin
            sel_idx = IDX_REG13;
        end else if (paddr == PRIO_CTRL_14_OFFS) begin
            sel_idx = IDX_REG14;
        end else begin
            addr_hit = 1'b0;
        end
    end

    always_comb begin
        prdata_next = '0;
        pslverr_next = !addr_hit;
        if (addr_hit && !pwrite) begin
            prdata_next = {{(APB_DATA_W-REG_W){1'b0}}, regs[sel_idx]};
        end
    end

    // Read data is frozen at setup; no other transfer can alter it first
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end else if (pready_reg) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end
    end

    // One wait-free access phase per transfer
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup_ph;
        end
    end

    assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;

    // Byte lanes above the low two carry nothing and are dropped
    always_comb begin
        wr_word = regs[sel_idx];
        if (pstrb[0]) begin
            wr_word[BYTE_LO_LSB +: 8] = pwdata[BYTE_LO_LSB +: 8];
        end
        if (pstrb[1]) begin
            wr_word[BYTE_HI_LSB +: 8] = pwdata[BYTE_HI_LSB +: 8];
        end
    end

    for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
        assign wr_en[r] = wr_fire && (sel_idx == 3'(r));
        prio_reg_cell #(
            .IMPL_MASK(REG_MASKS[r])
        ) u_cell (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .wr_en_i(wr_en[r]),
            .wr_data_i(wr_word),
            .value_o(regs[r]),
            .src_on_o(src_on[r])
        );
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign src_on_o = src_on;

    // Field placement toward the arbiter
    always_comb begin
        prio_o.can1_event_prio = regs[IDX_REG8][FLD3_LSB +: FIELD_W];
        prio_o.can1_rx_ready_prio = regs[IDX_REG8][FLD2_LSB +: FIELD_W];
        prio_o.spi_two_event_prio = regs[IDX_REG8][FLD1_LSB +: FIELD_W];
        prio_o.spi_two_error_prio = regs[IDX_REG8][FLD0_LSB +: FIELD_W];
        prio_o.capture5_prio = regs[IDX_REG9][FLD3_LSB +: FIELD_W];
        prio_o.capture4_prio = regs[IDX_REG9][FLD2_LSB +: FIELD_W];
        prio_o.capture3_prio = regs[IDX_REG9][FLD1_LSB +: FIELD_W];
        prio_o.dma_ch3_done_prio = regs[IDX_REG9][FLD0_LSB +: FIELD_W];
        prio_o.compare7_prio = regs[IDX_REG10][FLD3_LSB +: FIELD_W];
        prio_o.compare6_prio = regs[IDX_REG10][FLD2_LSB +: FIELD_W];
        prio_o.compare5_prio = regs[IDX_REG10][FLD1_LSB +: FIELD_W];
        prio_o.capture6_prio = regs[IDX_REG10][FLD0_LSB +: FIELD_W];
        prio_o.timer6_prio = regs[IDX_REG11][FLD3_LSB +: FIELD_W];
        prio_o.dma_ch4_done_prio = regs[IDX_REG11][FLD2_LSB +: FIELD_W];
        prio_o.compare8_prio = regs[IDX_REG11][FLD0_LSB +: FIELD_W];
        prio_o.timer8_prio = regs[IDX_REG12][FLD3_LSB +: FIELD_W];
        prio_o.i2c_two_master_prio = regs[IDX_REG12][FLD2_LSB +: FIELD_W];
        prio_o.i2c_two_slave_prio = regs[IDX_REG12][FLD1_LSB +: FIELD_W];
        prio_o.timer7_prio = regs[IDX_REG12][FLD0_LSB +: FIELD_W];
        prio_o.can2_rx_ready_prio = regs[IDX_REG13][FLD3_LSB +: FIELD_W];
        prio_o.ext_irq4_prio = regs[IDX_REG13][FLD2_LSB +: FIELD_W];
        prio_o.ext_irq3_prio = regs[IDX_REG13][FLD1_LSB +: FIELD_W];
        prio_o.timer9_prio = regs[IDX_REG13][FLD0_LSB +: FIELD_W];
        prio_o.codec_if_error_prio = regs[IDX_REG14][FLD3_LSB +: FIELD_W];
        prio_o.can2_event_prio = regs[IDX_REG14][FLD0_LSB +: FIELD_W];
    end

    // Checks

    logic wr8_hi;
    logic wr_lo_any;
    assign wr8_hi = wr_fire && sel_idx == IDX_REG8 && pstrb[1];
    assign wr_lo_any = wr_fire && pstrb[0];

    property p_level_seven;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr8_hi && pwdata[FLD3_LSB +: FIELD_W] == PRIO_HIGHEST)
            |=> (prio_o.can1_event_prio == PRIO_HIGHEST)
                && src_on[IDX_REG8][FLD3_LSB / NIBBLE_W];
    endproperty
    a_level_seven: assert property (p_level_seven)
        else $error("code 111 did not give level 7");

    property p_level_one;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_lo_any && sel_idx == IDX_REG12 && pwdata[FLD0_LSB +: FIELD_W] == PRIO_LOWEST)
            |=> prio_o.timer7_prio == PRIO_LOWEST && src_on[IDX_REG12][0];
    endproperty
    a_level_one: assert property (p_level_one)
        else $error("code 001 did not give enabled level 1");

    property p_disabled;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (prio_o.spi_two_error_prio == PRIO_DISABLED) == !src_on[IDX_REG8][0];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("enable flag disagrees with field code");

    property p_unused_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        pready |-> (prdata[APB_DATA_W-1:REG_W] == '0)
            && (prdata[REG_W-1:0] & ~MASK_FULL) == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit read as one");

    property p_reset_pattern;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> regs == {REG_MASKS[6] & RESET_PATTERN,
            REG_MASKS[5] & RESET_PATTERN, REG_MASKS[4] & RESET_PATTERN,
            REG_MASKS[3] & RESET_PATTERN, REG_MASKS[2] & RESET_PATTERN,
            REG_MASKS[1] & RESET_PATTERN, REG_MASKS[0] & RESET_PATTERN};
    endproperty
    a_reset_pattern: assert property (p_reset_pattern)
        else $error("reset value wrong after release");

    property p_reset_level4;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> prio_o.can2_event_prio == PRIO_DEFAULT
            && prio_o.timer6_prio == PRIO_DEFAULT && prio_o.ext_irq3_prio == PRIO_DEFAULT
            && prio_o.codec_if_error_prio == PRIO_DEFAULT;
    endproperty
    a_reset_level4: assert property (p_reset_level4)
        else $error("source not at level 4 after reset");

    property p_map_reg8;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG8 && pstrb[0])
            |=> prio_o.spi_two_event_prio == $past(pwdata[FLD1_LSB +: FIELD_W]);
    endproperty
    a_map_reg8: assert property (p_map_reg8)
        else $error("reg 8 field placement wrong");

    property p_map_reg9;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG9 && pstrb[1])
            |=> prio_o.capture4_prio == $past(pwdata[FLD2_LSB +: FIELD_W]);
    endproperty
    a_map_reg9: assert property (p_map_reg9)
        else $error("reg 9 field placement wrong");

    property p_map_reg10;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG10 && pstrb[0])
            |=> prio_o.capture6_prio == $past(pwdata[FLD0_LSB +: FIELD_W]);
    endproperty
    a_map_reg10: assert property (p_map_reg10)
        else $error("reg 10 field placement wrong");

    property p_map_reg11;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG11 && pstrb[0])
            |=> regs[IDX_REG11][FLD1_LSB +: NIBBLE_W] == '0
                && regs[IDX_REG11][FLD0_LSB + FIELD_W] == 1'b0;
    endproperty
    a_map_reg11: assert property (p_map_reg11)
        else $error("reg 11 bits 7-3 took a write");

    property p_map_reg12;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG12 && pstrb[1])
            |=> prio_o.timer8_prio == $past(pwdata[FLD3_LSB +: FIELD_W]);
    endproperty
    a_map_reg12: assert property (p_map_reg12)
        else $error("reg 12 field placement wrong");

    property p_map_reg13;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG13 && pstrb[1])
            |=> prio_o.ext_irq4_prio == $past(pwdata[FLD2_LSB +: FIELD_W]);
    endproperty
    a_map_reg13: assert property (p_map_reg13)
        else $error("reg 13 field placement wrong");

    property p_map_reg14;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG14)
            |=> (regs[IDX_REG14] & ~MASK_REG14) == '0;
    endproperty
    a_map_reg14: assert property (p_map_reg14)
        else $error("reg 14 bits 11-3 took a write");

    property p_write_readback;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && pstrb[1:0] == 2'h3)
            |=> regs[$past(sel_idx)] == ($past(pwdata[REG_W-1:0]) & REG_MASKS[$past(sel_idx)]);
    endproperty
    a_write_readback: assert property (p_write_readback)
        else $error("write did not store masked word");

    property p_read_value;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (setup_ph && !pwrite && addr_hit)
            |=> pready && prdata[REG_W-1:0] == regs[$past(sel_idx)];
    endproperty
    a_read_value: assert property (p_read_value)
        else $error("read data not the register");

    property p_ready_once;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        setup_ph |=> pready ##1 !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready not a single access cycle");

    // The refused write would land one edge after the access cycle
    property p_unmapped;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (setup_ph && !addr_hit) ##1 pready |-> pslverr ##1 $stable(regs);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_err_with_ready;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr outside the access cycle");

    property p_idle_rdata_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !pready |-> prdata == '0;
    endproperty
    a_idle_rdata_zero: assert property (p_idle_rdata_zero)
        else $error("read data not zero outside access");

    property p_unmapped_rdata;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (setup_ph && !addr_hit) |=> prdata == '0;
    endproperty
    a_unmapped_rdata: assert property (p_unmapped_rdata)
        else $error("unmapped read returned data");

    property p_unused_slots;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !src_on[IDX_REG11][FLD1_LSB / NIBBLE_W]
            && src_on[IDX_REG14][FLD2_LSB / NIBBLE_W : FLD1_LSB / NIBBLE_W] == '0
            && (regs[IDX_REG11] & ~MASK_REG11) == '0
            && (regs[IDX_REG14] & ~MASK_REG14) == '0;
    endproperty
    a_unused_slots: assert property (p_unused_slots)
        else $error("unimplemented slot holds a value");

    property p_code_enable;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (prio_o.dma_ch3_done_prio == PRIO_DISABLED) == !src_on[IDX_REG9][0];
    endproperty
    a_code_enable: assert property (p_code_enable)
        else $error("dma ch3 enable flag disagrees with code");

    property p_no_lane_write;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && pstrb[1:0] == 2'h0) |=> $stable(regs);
    endproperty
    a_no_lane_write: assert property (p_no_lane_write)
        else $error("write without low lanes changed a register");

    property p_high_lane_kept;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_fire && sel_idx == IDX_REG8 && pstrb[1:0] == 2'h1)
            |=> $stable(regs[IDX_REG8][BYTE_HI_LSB +: 8]);
    endproperty
    a_high_lane_kept: assert property (p_high_lane_kept)
        else $error("unstrobed byte lane changed");
endmodule : prio_ctrl_regs
`default_nettype wire

// *** testbench/apb_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module apb_host_model
    import prio_regs_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [APB_ADDR_W-1:0] paddr,
    output logic [APB_DATA_W-1:0] pwdata,
    output logic [APB_STRB_W-1:0] pstrb,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
    end

    // Called right after a rising edge; returns at the edge that saw pready
    task automatic xfer(input logic wr, input logic [APB_ADDR_W-1:0] a,
                        input logic [APB_DATA_W-1:0] d, input logic [APB_STRB_W-1:0] s,
                        output logic [APB_DATA_W-1:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        // No wait-state count assumed; only the bench timeout ends this
        do @(posedge sys_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask : xfer

    // Released bus shows inverted values so stale data cannot pass
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : idle
endmodule : apb_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import prio_regs_pkg::*;

    typedef struct packed {
        int idx;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic [15:0] rexp;
    } row_t;

    localparam logic [15:0] IMPL_MASK [7] = '{16'h7777, 16'h7777, 16'h7777, 16'h7707,
                                             16'h7777, 16'h7777, 16'h7007};
    localparam row_t ROWS [10] = '{
        '{0, 32'hffff_ffff, 4'hf, 16'h7777},
        '{1, 32'h0000_0000, 4'hf, 16'h0000},
        '{2, 32'h0000_1111, 4'hf, 16'h1111},
        '{3, 32'hffff_ffff, 4'hf, 16'h7707},
        '{4, 32'h0000_a3d1, 4'hf, 16'h2351},
        '{5, 32'h0000_e5c3, 4'hf, 16'h6543},
        '{6, 32'hffff_ffff, 4'hf, 16'h7007},
        '{0, 32'h0000_0000, 4'h1, 16'h7700},
        '{2, 32'h0000_7000, 4'h2, 16'h7011},
        '{6, 32'h0000_0000, 4'hc, 16'h7007}
    };
    localparam logic [11:0] BAD_ADDR [3] = '{12'h01c, 12'h002, 12'hffc};

    logic sys_clk_i;
    logic rst_n_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
    logic [APB_STRB_W-1:0] pstrb;
    logic [APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    prio_fields_t prio_o;
    logic [27:0] src_on_o;
    logic [15:0] shadow [7];
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    prio_ctrl_regs i_prio_ctrl_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .prio_o(prio_o),
        .src_on_o(src_on_o));

    apb_host_model i_apb_host_model (.sys_clk_i(sys_clk_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_err(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_err

    // Arbitration view rebuilt from the register images, MSB field first
    task automatic check_arb();
        logic [74:0] pexp;
        logic [27:0] sexp;
        int pos;
        pexp = '0;
        sexp = '0;
        pos = 75;
        for (int i = 0; i < 7; i++) begin
            for (int f = 3; f >= 0; f--) begin
                if (IMPL_MASK[i][f*4]) begin
                    pos -= 3;
                    pexp[pos+:3] = shadow[i][f*4+:3];
                    sexp[i*4+f] = (shadow[i][f*4+:3] != 3'h0);
                end
            end
        end
        total_checks += 2;
        if ({prio_o} !== pexp || src_on_o !== sexp) begin
            mismatches++;
            $display("wrong value at %0t: got %h %h expected %h %h", $time, prio_o, src_on_o,
                     pexp, sexp);
        end
    endtask : check_arb

    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] rd, output logic err);
        i_apb_host_model.xfer(wr, a, d, s, rd, err);
    endtask : access

    task automatic check_all();
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < 7; i++) begin
            access(1'b0, 12'(4 * i), 32'h0, 4'h0, rd, err);
            check_word(rd, {16'h0, shadow[i]});
            check_err(err, 1'b0);
        end
        i_apb_host_model.idle();
        @(posedge sys_clk_i);
        check_arb();
    endtask : check_all

    task automatic reset_shadow();
        for (int i = 0; i < 7; i++)
            shadow[i] = 16'h4444 & IMPL_MASK[i];
    endtask : reset_shadow

    initial begin
        logic [31:0] rd;
        logic err;
        rst_n_i = 1'b0;
        reset_shadow();
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        check_all();
        $display("test reset defaults ended");
        // Write then read back to back, no idle cycle between
        foreach (ROWS[n]) begin
            access(1'b1, 12'(4 * ROWS[n].idx), ROWS[n].wdata, ROWS[n].strb, rd, err);
            check_err(err, 1'b0);
            access(1'b0, 12'(4 * ROWS[n].idx), 32'h0, 4'h0, rd, err);
            check_word(rd, {16'h0, ROWS[n].rexp});
            shadow[ROWS[n].idx] = ROWS[n].rexp;
            i_apb_host_model.idle();
            @(posedge sys_clk_i);
            check_arb();
        end
        $display("test table ended");
        foreach (BAD_ADDR[n]) begin
            access(1'b1, BAD_ADDR[n], 32'h0000_0000, 4'hf, rd, err);
            check_err(err, 1'b1);
            access(1'b0, BAD_ADDR[n], 32'h0, 4'h0, rd, err);
            check_err(err, 1'b1);
            check_word(rd, 32'h0);
        end
        i_apb_host_model.idle();
        @(posedge sys_clk_i);
        check_all();
        $display("test unmapped ended");
        rst_n_i <= 1'b0;
        @(posedge sys_clk_i);
        reset_shadow();
        @(negedge sys_clk_i);
        check_arb();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        check_all();
        $display("test mid-run reset ended");
        test_done();
    end
endmodule : testbench
`default_nettype wire
